// >>> src/rtc_irq_clkout.sv
// Alarm, periodic interrupt and 32 kHz clock output with its serial register port
`timescale 1ns/1ps

module rtc_irq_clkout (
  // Clock and reset
  input  wire logic                                 mclk_in,
  input  wire logic                                 rst_n_in,
  // Serial register port
  input  wire logic                                 ce_in,
  input  wire logic                                 sclk_in,
  input  wire logic                                 sio_in,
  output logic                                      sio_out,
  output logic                                      sio_oe_out,
  // Time base from the counters
  input  wire logic                                 sec_tick_in,
  input  wire logic [rtc_irq_pkg::SUB_SEC_W-1:0]    sub_sec_in,
  input  wire logic [7:0]                           second_in,
  input  wire logic [7:0]                           minute_in,
  input  wire logic [7:0]                           hour_in,
  input  wire logic [7:0]                           day_in,
  input  wire logic [2:0]                           weekday_in,
  // Alarm settings
  input  wire logic [6:0]                           alarm_w_week_in,
  input  wire logic [7:0]                           alarm_w_hour_in,
  input  wire logic [7:0]                           alarm_w_minute_in,
  input  wire logic [7:0]                           alarm_d_hour_in,
  input  wire logic [7:0]                           alarm_d_minute_in,
  // Oscillator supervision
  input  wire logic                                 osc_stop_detect_in,
  // Clock output
  input  wire logic                                 clk32k_in,
  input  wire logic                                 clkout_control_pin_in,
  output logic                                      clkout_pin_out,
  // Open drain interrupt pin
  input  wire logic                                 irq_out_n_in,
  output logic                                      irq_out_n_out,
  output logic                                      irq_oe_out
);
  import rtc_irq_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] ce_s;
    logic [2:0] sclk_s;
    logic [2:0] sio_s;
    logic [2:0] clk32_s;
    logic [2:0] clkctl_s;
    logic [2:0] halt_s;
    logic       ce_f;
    logic       sclk_f;
    logic       sio_f;
    logic       clk32_f;
    logic       clkctl_f;
    logic       halt_f;
    logic [4:0] bit_cnt;
    logic [7:0] shift_in;
    logic [3:0] cmd_addr;
    logic       cmd_read;
    logic [7:0] shift_out;
    logic       sio_drive;
    logic       week_alarm_enable;
    logic       day_alarm_enable;
    logic       clkout_enable_n_b;
    logic [2:0] period_select;
    logic       clkout_enable_n_a;
    logic       periodic_flag;
    logic       week_alarm_flag;
    logic       day_alarm_flag;
    logic       osc_halt_flag;
    logic       week_match_d;
    logic       day_match_d;
    logic       pulse_low_d;
    logic       irq_low;
    logic       clkout;
  } state_t;

  state_t s;
  state_t next_s;

  // ----------------------------------------------------------------
  // Register read view
  // ----------------------------------------------------------------
  function automatic logic [7:0] read_reg(input state_t st, input logic [3:0] addr);
    logic [7:0] v;
    v = 8'h00;
    if (addr == ADDR_CTRL) begin
      v[CTRL_WEEK_EN_BIT]               = st.week_alarm_enable;
      v[CTRL_DAY_EN_BIT]                = st.day_alarm_enable;
      v[CTRL_CLKEN_B_BIT]               = st.clkout_enable_n_b;
      v[CTRL_PSEL_LSB +: 3]             = st.period_select;
    end else if (addr == ADDR_STAT) begin
      v[STAT_HALT_BIT]                  = st.osc_halt_flag;
      v[STAT_CLKEN_A_BIT]               = st.clkout_enable_n_a;
      v[STAT_PER_BIT]                   = st.periodic_flag;
      v[STAT_WEEK_BIT]                  = st.week_alarm_flag;
      v[STAT_DAY_BIT]                   = st.day_alarm_flag;
    end
    return v;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic       sclk_rise;
    logic       sclk_fall;
    logic [7:0] shifted;
    logic [7:0] cur;
    logic [7:0] wval;
    logic       wr_hi;
    logic       wr_lo;
    logic       week_match;
    logic       day_match;
    logic       level_mode;
    logic       pulse_mode;
    logic       pulse_low;
    logic       level_event;
    logic       halt_rise;
    sclk_rise   = 1'b0;
    sclk_fall   = 1'b0;
    shifted     = 8'h00;
    cur         = 8'h00;
    wval        = 8'h00;
    wr_hi       = 1'b0;
    wr_lo       = 1'b0;
    week_match  = 1'b0;
    day_match   = 1'b0;
    level_mode  = 1'b0;
    pulse_mode  = 1'b0;
    pulse_low   = 1'b0;
    level_event = 1'b0;
    halt_rise   = 1'b0;
    next_s      = s;

    // Pin synchronisers and agreement filters
    next_s.ce_s     = {s.ce_s[1:0], ce_in};
    next_s.sclk_s   = {s.sclk_s[1:0], sclk_in};
    next_s.sio_s    = {s.sio_s[1:0], sio_in};
    next_s.clk32_s  = {s.clk32_s[1:0], clk32k_in};
    next_s.clkctl_s = {s.clkctl_s[1:0], clkout_control_pin_in};
    next_s.halt_s   = {s.halt_s[1:0], osc_stop_detect_in};
    if (s.ce_s[1] == s.ce_s[2]) begin
      next_s.ce_f = s.ce_s[2];
    end
    if (s.sclk_s[1] == s.sclk_s[2]) begin
      next_s.sclk_f = s.sclk_s[2];
    end
    if (s.sio_s[1] == s.sio_s[2]) begin
      next_s.sio_f = s.sio_s[2];
    end
    if (s.clk32_s[1] == s.clk32_s[2]) begin
      next_s.clk32_f = s.clk32_s[2];
    end
    if (s.clkctl_s[1] == s.clkctl_s[2]) begin
      next_s.clkctl_f = s.clkctl_s[2];
    end
    if (s.halt_s[1] == s.halt_s[2]) begin
      next_s.halt_f = s.halt_s[2];
    end
    sclk_rise = next_s.sclk_f & ~s.sclk_f;
    sclk_fall = ~next_s.sclk_f & s.sclk_f;

    // Serial transfer
    if (!s.ce_f) begin
      next_s.bit_cnt   = 5'h00;
      next_s.sio_drive = 1'b0;
      next_s.cmd_read  = 1'b0;
    end else if (sclk_rise && s.bit_cnt != SER_DONE) begin
      shifted          = {s.shift_in[6:0], s.sio_f};
      next_s.shift_in  = shifted;
      next_s.bit_cnt   = s.bit_cnt + 5'h01;
      if (s.bit_cnt == SER_CMD_LAST) begin
        next_s.cmd_addr = shifted[7:4];
        next_s.cmd_read = (shifted[3:0] == SER_MODE_READ);
        if (shifted[3:0] == SER_MODE_READ) begin
          next_s.shift_out = read_reg(s, shifted[7:4]);
          next_s.sio_drive = 1'b1;
        end
      end else if (!s.cmd_read && s.bit_cnt == SER_HI_LAST) begin
        wr_hi = 1'b1;
      end else if (!s.cmd_read && s.bit_cnt == SER_LO_LAST) begin
        wr_lo = 1'b1;
      end
    end else if (sclk_fall && s.sio_drive) begin
      next_s.shift_out = {s.shift_out[6:0], 1'b0};
    end
    if (s.bit_cnt == SER_DONE && sclk_fall) begin
      next_s.sio_drive = 1'b0;
    end

    // Nibble commit
    cur  = read_reg(s, s.cmd_addr);
    wval = wr_hi ? {shifted[3:0], cur[3:0]} : {cur[7:4], shifted[3:0]};
    if ((wr_hi || wr_lo) && s.cmd_addr == ADDR_CTRL) begin
      next_s.week_alarm_enable = wval[CTRL_WEEK_EN_BIT];
      next_s.day_alarm_enable  = wval[CTRL_DAY_EN_BIT];
      next_s.clkout_enable_n_b = wval[CTRL_CLKEN_B_BIT];
      next_s.period_select     = wval[CTRL_PSEL_LSB +: 3];
    end else if ((wr_hi || wr_lo) && s.cmd_addr == ADDR_STAT) begin
      next_s.clkout_enable_n_a = wval[STAT_CLKEN_A_BIT];
      if (wr_hi && !wval[STAT_HALT_BIT]) begin
        next_s.osc_halt_flag = 1'b0;
      end
      if (wr_lo && !wval[STAT_PER_BIT]) begin
        next_s.periodic_flag = 1'b0;
      end
      if (wr_lo && !wval[STAT_WEEK_BIT]) begin
        next_s.week_alarm_flag = 1'b0;
      end
      if (wr_lo && !wval[STAT_DAY_BIT]) begin
        next_s.day_alarm_flag = 1'b0;
      end
    end

    // Alarm comparison
    week_match = s.week_alarm_enable && weekday_in <= WEEKDAY_LAST
                 && alarm_w_week_in[weekday_in]
                 && hour_in == alarm_w_hour_in && minute_in == alarm_w_minute_in;
    day_match  = s.day_alarm_enable && hour_in == alarm_d_hour_in
                 && minute_in == alarm_d_minute_in;
    next_s.week_match_d = week_match;
    next_s.day_match_d  = day_match;
    if (week_match && !s.week_match_d) begin
      next_s.week_alarm_flag = 1'b1;
    end
    if (day_match && !s.day_match_d) begin
      next_s.day_alarm_flag = 1'b1;
    end

    // Periodic source
    level_mode = s.period_select[2];
    pulse_mode = (s.period_select == PSEL_2HZ)
                 || (s.period_select == PSEL_1HZ);
    case (s.period_select)
      PSEL_2HZ:   pulse_low = ~sub_sec_in[SUB_2HZ_BIT];
      PSEL_1HZ:   pulse_low = ~sub_sec_in[SUB_1HZ_BIT];
      PSEL_SEC:   level_event = sec_tick_in;
      PSEL_MIN:   level_event = sec_tick_in && second_in == BCD_ZERO;
      PSEL_HOUR:  level_event = sec_tick_in && second_in == BCD_ZERO
                                && minute_in == BCD_ZERO;
      PSEL_MONTH: level_event = sec_tick_in && second_in == BCD_ZERO
                                && minute_in == BCD_ZERO && hour_in == BCD_ZERO
                                && day_in == BCD_ONE;
      default:    pulse_low = 1'b0;
    endcase
    next_s.pulse_low_d = pulse_low;
    if (level_event || (pulse_low && !s.pulse_low_d)) begin
      next_s.periodic_flag = 1'b1;
    end

    // Oscillation halt capture and clear
    if (next_s.halt_f && !s.ce_f) begin
      next_s.osc_halt_flag = 1'b1;
    end
    halt_rise = next_s.osc_halt_flag && !s.osc_halt_flag;
    if (halt_rise) begin
      next_s.week_alarm_enable = RST_ENABLE;
      next_s.day_alarm_enable  = RST_ENABLE;
      next_s.period_select     = RST_PSEL;
      next_s.clkout_enable_n_a = RST_CLKEN_N;
      next_s.clkout_enable_n_b = RST_CLKEN_N;
      next_s.periodic_flag     = RST_FLAG;
      next_s.week_alarm_flag   = RST_FLAG;
      next_s.day_alarm_flag    = RST_FLAG;
    end

    // Interrupt combine
    next_s.irq_low = next_s.week_alarm_flag || next_s.day_alarm_flag
                     || (level_mode && next_s.periodic_flag)
                     || (s.period_select == PSEL_LOW)
                     || (pulse_mode && pulse_low);
    if (halt_rise) begin
      next_s.irq_low = 1'b0;
    end

    // Clock output gate
    if (next_s.clkctl_f && (!next_s.clkout_enable_n_a || !next_s.clkout_enable_n_b)) begin
      next_s.clkout = s.clk32_f;
    end else begin
      next_s.clkout = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s                   <= '0;
      s.week_alarm_enable <= RST_ENABLE;
      s.day_alarm_enable  <= RST_ENABLE;
      s.period_select     <= RST_PSEL;
      s.clkout_enable_n_a <= RST_CLKEN_N;
      s.clkout_enable_n_b <= RST_CLKEN_N;
      s.periodic_flag     <= RST_FLAG;
      s.week_alarm_flag   <= RST_FLAG;
      s.day_alarm_flag    <= RST_FLAG;
      s.osc_halt_flag     <= RST_HALT;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign sio_out        = s.shift_out[7];
  assign sio_oe_out     = s.sio_drive;
  assign clkout_pin_out = s.clkout;
  assign irq_out_n_out  = 1'b0;
  assign irq_oe_out     = s.irq_low;

endmodule // rtc_irq_clkout

// >>> src/rtc_irq_pkg.sv
// Constants for the alarm, periodic interrupt and clock output block
package rtc_irq_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL        = 4'hE;
  localparam logic [3:0] ADDR_STAT        = 4'hF;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int         CTRL_WEEK_EN_BIT = 7;
  localparam int         CTRL_DAY_EN_BIT  = 6;
  localparam int         CTRL_CLKEN_B_BIT = 4;
  localparam int         CTRL_PSEL_LSB    = 0;
  localparam int         STAT_HALT_BIT    = 5;
  localparam int         STAT_CLKEN_A_BIT = 3;
  localparam int         STAT_PER_BIT     = 2;
  localparam int         STAT_WEEK_BIT    = 1;
  localparam int         STAT_DAY_BIT     = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic       RST_ENABLE       = 1'b0;
  localparam logic [2:0] RST_PSEL         = 3'h0;
  localparam logic       RST_CLKEN_N      = 1'b0;
  localparam logic       RST_FLAG         = 1'b0;
  localparam logic       RST_HALT         = 1'b1;

  // ----------------------------------------------------------------
  // Period select codes
  // ----------------------------------------------------------------
  localparam logic [2:0] PSEL_OFF         = 3'h0;
  localparam logic [2:0] PSEL_LOW         = 3'h1;
  localparam logic [2:0] PSEL_2HZ         = 3'h2;
  localparam logic [2:0] PSEL_1HZ         = 3'h3;
  localparam logic [2:0] PSEL_SEC         = 3'h4;
  localparam logic [2:0] PSEL_MIN         = 3'h5;
  localparam logic [2:0] PSEL_HOUR        = 3'h6;
  localparam logic [2:0] PSEL_MONTH       = 3'h7;

  // ----------------------------------------------------------------
  // Serial port framing
  // ----------------------------------------------------------------
  localparam logic [3:0] SER_MODE_WRITE   = 4'h0;
  localparam logic [3:0] SER_MODE_READ    = 4'h4;
  localparam logic [4:0] SER_CMD_LAST     = 5'h07;
  localparam logic [4:0] SER_HI_LAST      = 5'h0B;
  localparam logic [4:0] SER_LO_LAST      = 5'h0F;
  localparam logic [4:0] SER_DONE         = 5'h10;

  // ----------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------
  localparam int         SUB_SEC_W        = 15;
  localparam int         SUB_2HZ_BIT      = 13;
  localparam int         SUB_1HZ_BIT      = 14;
  localparam logic [7:0] BCD_ZERO         = 8'h00;
  localparam logic [7:0] BCD_ONE          = 8'h01;
  localparam logic [2:0] WEEKDAY_LAST     = 3'h6;

endpackage

// >>> verif/rtc_host_model.sv
// Host processor model driving the three-wire register port
`timescale 1ns/1ps

module rtc_host_model (
  // Clock
  input  wire logic mclk_in,
  // Serial port pins
  input  wire logic sio_in,
  output logic      ce_out,
  output logic      sclk_out,
  output logic      sio_drv_out,
  output logic      sio_en_out
);
  import rtc_irq_pkg::*;

  localparam int HALF = 8;

  // Chip select held low from power-up
  initial begin
    ce_out      = 1'b0;
    sclk_out    = 1'b0;
    sio_drv_out = 1'b0;
    sio_en_out  = 1'b0;
  end

  // ----------------------------------------------------------------
  // One frame of n bits; a short frame ends the transfer but keeps a high nibble already shifted in (12 bits)
  // ----------------------------------------------------------------
  task automatic xfer(input logic [3:0] a, input logic [3:0] m, input logic [7:0] d,
                      input int n, output logic [7:0] q);
    logic [15:0] f;
    f = {a, m, d};
    q = 8'h00;
    @(negedge mclk_in);
    ce_out = 1'b1;
    repeat (HALF) @(negedge mclk_in);
    for (int i = 0; i < n; i++) begin
      sio_en_out  = !(m == SER_MODE_READ && i >= 8);
      sio_drv_out = f[15-i];
      repeat (HALF) @(negedge mclk_in);
      sclk_out = 1'b1;
      repeat (HALF) @(negedge mclk_in);
      if (i >= 7 && i < 15) q[14-i] = sio_in;
      sclk_out = 1'b0;
    end
    repeat (HALF) @(negedge mclk_in);
    ce_out     = 1'b0;
    sio_en_out = 1'b0;
    repeat (2 * HALF) @(negedge mclk_in);
  endtask

endmodule // rtc_host_model

// >>> verif/rtc_irq_clkout_asserts.sv
// Port-level assertions for the interrupt and clock output block
`timescale 1ns/1ps

module rtc_irq_clkout_asserts (
  // Clock and reset
  input wire logic                              mclk_in,
  input wire logic                              rst_n_in,
  // Observed inputs
  input wire logic                              ce_in,
  input wire logic                              sec_tick_in,
  input wire logic [rtc_irq_pkg::SUB_SEC_W-1:0] sub_sec_in,
  input wire logic [7:0]                        minute_in,
  input wire logic [7:0]                        hour_in,
  input wire logic [2:0]                        weekday_in,
  input wire logic [6:0]                        alarm_w_week_in,
  input wire logic [7:0]                        alarm_w_hour_in,
  input wire logic [7:0]                        alarm_w_minute_in,
  input wire logic [7:0]                        alarm_d_hour_in,
  input wire logic [7:0]                        alarm_d_minute_in,
  input wire logic                              osc_stop_detect_in,
  input wire logic                              clk32k_in,
  input wire logic                              clkout_control_pin_in,
  // Observed outputs
  input wire logic                              sio_oe_out,
  input wire logic                              clkout_pin_out,
  input wire logic                              irq_out_n_out,
  input wire logic                              irq_oe_out
);
  logic [7:0] clk_hist;
  logic       alarm_hit;
  logic       wave_low;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  // Recent clock input samples
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      clk_hist <= 8'h00;
    end else begin
      clk_hist <= {clk_hist[6:0], clk32k_in};
    end
  end

  assign wave_low  = !sub_sec_in[13] || !sub_sec_in[14];
  assign alarm_hit = (hour_in == alarm_d_hour_in && minute_in == alarm_d_minute_in) ||
                     (weekday_in != 3'h7 && alarm_w_week_in[weekday_in] &&
                      hour_in == alarm_w_hour_in && minute_in == alarm_w_minute_in);

  sequence ce_idle;
    !ce_in [*7];
  endsequence

  sequence halt_seen;
    (osc_stop_detect_in && !ce_in) [*8];
  endsequence

  property irq_has_cause;
    $rose(irq_oe_out) |-> $past(sec_tick_in) || $past(alarm_hit) || $past(ce_in) ||
                          $past(wave_low);
  endproperty

  chk_pull_only: assert property (irq_out_n_out == 1'b0)
    else $error("interrupt pin driven high");
  chk_reset_quiet: assert property ($rose(rst_n_in) |-> !irq_oe_out [*8])
    else $error("interrupt asserted after reset");
  chk_read_abort: assert property (ce_idle |-> !sio_oe_out)
    else $error("data driven with chip select low");
  chk_read_start: assert property ($rose(sio_oe_out) |-> $past(ce_in, 8))
    else $error("data drive began outside a frame");
  chk_clk_gated: assert property (!clkout_control_pin_in [*8] |-> !clkout_pin_out)
    else $error("clock output active with control pin low");
  chk_clk_source: assert property (clkout_pin_out |-> (|clk_hist))
    else $error("clock output high without source clock");
  chk_halt_clear: assert property (halt_seen |-> ##[0:4] !irq_oe_out)
    else $error("interrupt held after oscillator halt");
  chk_irq_cause: assert property (irq_has_cause)
    else $error("interrupt asserted without a source");

endmodule // rtc_irq_clkout_asserts

bind rtc_irq_clkout rtc_irq_clkout_asserts u_chk (.*);

// >>> verif/rtc_irq_clkout_tb.sv
// Self-checking bench for the interrupt and clock output block
`timescale 1ns/1ps

module rtc_irq_clkout_tb;
  import rtc_irq_pkg::*;

  logic        mclk_in = 1'b0, rst_n_in = 1'b0, ce_in, sclk_in, sio_in, sio_out, sio_oe_out;
  logic        sec_tick_in = 1'b0, osc_stop_detect_in = 1'b0, clk32k_in = 1'b0;
  logic [14:0] sub_sec_in = 15'h0000;
  logic [7:0]  second_in = 8'h00, minute_in = 8'h00, hour_in = 8'h00, day_in = 8'h01;
  logic [2:0]  weekday_in = 3'h0;
  logic [6:0]  alarm_w_week_in = 7'h00;
  logic [7:0]  alarm_w_hour_in = 8'h00, alarm_w_minute_in = 8'h00;
  logic [7:0]  alarm_d_hour_in = 8'h00, alarm_d_minute_in = 8'h00;
  logic        clkout_control_pin_in = 1'b0, clkout_pin_out, irq_out_n_in;
  logic        irq_out_n_out, irq_oe_out, sio_drv, sio_en, junk = 1'b0;
  logic [7:0]  q;
  int          error_cnt = 0, checks = 0, seed = 42, cyc = 0, n, h, m, w;

  always #4 mclk_in = ~mclk_in;
  always @(negedge mclk_in) junk <= ~junk;
  always @(negedge mclk_in) if (cyc % 12 == 0) clk32k_in <= ~clk32k_in;

  // Wire levels: released data line toggles, interrupt line pulled up
  assign sio_in       = sio_oe_out ? sio_out : (sio_en ? sio_drv : junk);
  assign irq_out_n_in = irq_oe_out ? irq_out_n_out : 1'b1;

  rtc_irq_clkout dut (.*);

  rtc_host_model host (.mclk_in(mclk_in), .sio_in(sio_in), .ce_out(ce_in),
                       .sclk_out(sclk_in), .sio_drv_out(sio_drv), .sio_en_out(sio_en));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic int rnd(input int lim);
    return $unsigned($random(seed)) % lim;
  endfunction
  function automatic logic [7:0] bcd(input int v);
    return {4'(v / 10), 4'(v % 10)};
  endfunction
  function automatic logic exp_pulse(input logic [2:0] p, input logic [14:0] s);
    return (p == PSEL_LOW) || (p == PSEL_2HZ && !s[SUB_2HZ_BIT]) ||
           (p == PSEL_1HZ && !s[SUB_1HZ_BIT]);
  endfunction
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wt(input int c);
    repeat (c) @(negedge mclk_in);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    host.xfer(a, SER_MODE_WRITE, d, 16, q);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string name);
    host.xfer(a, SER_MODE_READ, 8'h00, 16, q);
    check(name, q, e);
  endtask
  task automatic tick;
    sec_tick_in = 1'b1;
    wt(1);
    sec_tick_in = 1'b0;
    wt(3);
  endtask
  task automatic stop_test;
    $display("Checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      error_cnt++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    wt(10);
    rst_n_in = 1'b1;
    wt(4);
    rd(ADDR_CTRL, 8'h00, "ctrl reset");
    rd(ADDR_STAT, 8'h20, "stat reset");
    rd(4'h3, 8'h00, "unmapped");
    check("irq idle", irq_oe_out, 1'b0);
    wr(ADDR_STAT, 8'h07);
    rd(ADDR_STAT, 8'h00, "ones ignored");
    for (int p = 1; p < 4; p++) begin
      wr(ADDR_CTRL, 8'(p));
      for (int k = 0; k < 6; k++) begin
        sub_sec_in = (k == 0) ? 15'h7FFF : (k == 1) ? 15'h0000 : 15'(rnd(32768));
        wt(3);
        check("pulse irq", irq_oe_out, exp_pulse(3'(p), sub_sec_in));
      end
      if (p > 1) rd(ADDR_STAT, 8'h04, "pulse flag");
      wr(ADDR_CTRL, 8'h00);
      wr(ADDR_STAT, 8'h00);
    end
    for (int p = 4; p < 8; p++) begin
      wr(ADDR_CTRL, 8'(p));
      second_in = 8'h01;
      tick();
      check("level miss", irq_oe_out, p == 4);
      wr(ADDR_STAT, 8'h00);
      second_in = 8'h00;
      tick();
      check("level hit", irq_oe_out, 1'b1);
      rd(ADDR_STAT, 8'h04, "level flag");
      check("level hold", irq_oe_out, 1'b1);
      wr(ADDR_STAT, 8'h00);
      check("level clear", irq_oe_out, 1'b0);
    end
    h = rnd(24);
    m = rnd(60);
    w = rnd(7);
    wr(ADDR_CTRL, 8'h00);
    alarm_d_hour_in   = bcd(h);
    alarm_d_minute_in = bcd(m);
    alarm_w_hour_in   = bcd((h + 1) % 24);
    alarm_w_minute_in = bcd(m);
    alarm_w_week_in   = 7'h01 << w;
    weekday_in        = 3'(w);
    hour_in           = bcd(h);
    minute_in         = bcd((m + 1) % 60);
    wr(ADDR_CTRL, 8'hC0);
    minute_in = bcd(m);
    wt(3);
    check("day irq", irq_oe_out, 1'b1);
    rd(ADDR_STAT, 8'h01, "day flag");
    minute_in = bcd((m + 1) % 60);
    wr(ADDR_STAT, 8'h06);
    rd(ADDR_STAT, 8'h00, "day clear");
    check("day off", irq_oe_out, 1'b0);
    rd(ADDR_CTRL, 8'hC0, "en kept");
    minute_in = bcd(m);
    wt(3);
    check("day again", irq_oe_out, 1'b1);
    minute_in = bcd((m + 1) % 60);
    wr(ADDR_STAT, 8'h00);
    wr(ADDR_CTRL, 8'h80);
    minute_in = bcd(m);
    wt(3);
    check("day disabled", irq_oe_out, 1'b0);
    alarm_w_hour_in = bcd(h);
    wt(3);
    check("week irq", irq_oe_out, 1'b1);
    rd(ADDR_STAT, 8'h02, "week flag");
    wr(ADDR_CTRL, 8'hC0);
    rd(ADDR_STAT, 8'h03, "both flags");
    wr(ADDR_STAT, 8'h02);
    check("or hold", irq_oe_out, 1'b1);
    wr(ADDR_STAT, 8'h00);
    check("or clear", irq_oe_out, 1'b0);
    minute_in = bcd((m + 1) % 60);
    wr(ADDR_CTRL, 8'h12);
    host.xfer(ADDR_CTRL, SER_MODE_WRITE, 8'h80, 12, q);
    host.xfer(ADDR_CTRL, SER_MODE_READ, 8'h00, 10, q);
    rd(ADDR_CTRL, 8'h82, "nibble write");
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_STAT, {4'h0, c[0], 3'h0});
      wr(ADDR_CTRL, {3'h0, c[1], 4'h0});
      clkout_control_pin_in = c[2];
      wt(20);
      n = 0;
      repeat (100) begin
        @(negedge mclk_in);
        if (clkout_pin_out !== 1'b0) n++;
      end
      check("clkout", n > 0, c[2] && !(c[0] && c[1]));
    end
    wr(ADDR_CTRL, 8'hD1);
    check("irq forced", irq_oe_out, 1'b1);
    osc_stop_detect_in = 1'b1;
    wt(12);
    osc_stop_detect_in = 1'b0;
    check("halt irq", irq_oe_out, 1'b0);
    rd(ADDR_CTRL, 8'h00, "halt ctrl");
    rd(ADDR_STAT, 8'h20, "halt stat");
    stop_test();
  end

endmodule // rtc_irq_clkout_tb
